//--- its_defs.svh
// constants of the two-wire target select and framing block
`ifndef ITS_DEFS_SVH
`define ITS_DEFS_SVH

// device type code, value arbitrary
`define ITS_TYPE_ID      4'h5
// internal select bit value that reaches user memory
`define ITS_INT_SEL      1'b0
`define ITS_ADDR_W       13
`define ITS_DATA_W       8
`define ITS_MEM_BYTES    8192
`define ITS_FIFO_DEPTH   8
`define ITS_BITS_PER_BYTE 4'h8
`define ITS_LAST_BIT     4'h7
`define ITS_ADDR_HI_W    5
`define ITS_STRAP_RST    2'h0
`define ITS_TYPE_MSB     7
`define ITS_TYPE_LSB     4
`define ITS_SEL_POS      3
`define ITS_STRAP_MSB    2
`define ITS_STRAP_LSB    1
`define ITS_RW_POS       0

`endif

//--- its_pkg.sv
// types of the two-wire target select and framing block
package its_pkg;
`include "its_defs.svh"

	typedef enum logic [3:0] {
		ITS_IDLE    = 4'h0,
		ITS_DEVSEL  = 4'h1,
		ITS_ACK_SEL = 4'h3,
		ITS_ADDR_HI = 4'h2,
		ITS_ACK_HI  = 4'h6,
		ITS_ADDR_LO = 4'h7,
		ITS_ACK_LO  = 4'h5,
		ITS_WDATA   = 4'h4,
		ITS_ACK_W   = 4'hC,
		ITS_RDATA   = 4'hD,
		ITS_RACK    = 4'hF
	} its_state_e;

	typedef struct packed {
		logic [`ITS_ADDR_W-1:0] addr;
		logic [`ITS_DATA_W-1:0] data;
	} its_wreq_s;

endpackage

//--- its_fifo.sv
// first-in first-out buffer with valid and ready on both sides
`timescale 1ns/100ps
module its_fifo #(
	parameter int WIDTH = 21,
	parameter int DEPTH = 8
)(
	input  wire logic             clock,
	input  wire logic             nrst,
	input  wire logic             inValid,
	output logic                  inReady,
	input  wire logic [WIDTH-1:0] inData,
	output logic                  outValid,
	input  wire logic             outReady,
	output logic [WIDTH-1:0]      outData
);
	localparam int PW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [PW-1:0]    wrPtr_r;
	logic [PW-1:0]    rdPtr_r;
	logic [PW-1:0]    rdPtr_nxt;
	logic [PW:0]      count_r;
	logic [PW:0]      count_nxt;
	logic             push;
	logic             pop;

	assign push = inValid & inReady;
	assign pop = outValid & outReady;
	assign rdPtr_nxt = !pop ? rdPtr_r : (rdPtr_r == PW'(DEPTH - 1)) ? '0 : rdPtr_r + 1'b1;

	always_comb begin
		count_nxt = count_r;
		if (push && !pop) begin
			count_nxt = count_r + 1'b1;
		end else if (pop && !push) begin
			count_nxt = count_r - 1'b1;
		end
	end

	always_ff @(posedge clock) begin
		if (push) begin
			mem[wrPtr_r] <= inData;
		end
	end

	// head word kept in a flop so the output has no read mux behind it
	always_ff @(posedge clock) begin
		// a push into the slot that becomes the head bypasses the array
		outData <= (push && (wrPtr_r == rdPtr_nxt)) ? inData : mem[rdPtr_nxt];
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			wrPtr_r <= '0;
			rdPtr_r <= '0;
		end else begin
			if (push) begin
				wrPtr_r <= (wrPtr_r == PW'(DEPTH - 1)) ? '0 : wrPtr_r + 1'b1;
			end
			if (pop) begin
				rdPtr_r <= rdPtr_nxt;
			end
		end
	end

	// flags come from flops so neither side sees a combinational path through the other
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			count_r  <= '0;
			inReady  <= 1'b1;
			outValid <= 1'b0;
		end else begin
			count_r  <= count_nxt;
			inReady  <= (count_nxt != (PW+1)'(DEPTH));
			outValid <= (count_nxt != '0);
		end
	end

	fifoBound_a: assert property (@(posedge clock) disable iff (!nrst)
		count_r <= (PW+1)'(DEPTH))
		else $error("fifo count above depth");

endmodule

//--- its_target.sv
// two-wire bus target: select decode, byte framing, acknowledge, memory address space
//
// Overview of operation
// - target only; bus clock comes from the master and is never driven here
// - a matching select code is answered by an acknowledge on the data line
// - each written byte is acknowledged low in the ninth bit period while the write buffer has room; a byte that finds it full is not acknowledged
// - fixed built-in 4-bit type code forms the select code's upper nibble
// - select bits b2 and b1 are compared with the two strap inputs
// - unconnected strap inputs read as zero
// - data line is open drain: pull low or release, never drive high
// - every bit in or out is strobed by the serial clock
// - memory appears as 8192 byte-wide locations over the bus
// - select byte is sent msb first: type, internal select, straps, direction
`timescale 1ns/100ps
`include "its_defs.svh"
module its_target
	import its_pkg::*;
#(
	parameter logic [3:0] TYPE_ID    = `ITS_TYPE_ID,
	parameter logic       INT_SEL    = `ITS_INT_SEL,
	parameter int         FIFO_DEPTH = `ITS_FIFO_DEPTH
)(
	input  wire logic                   clock,
	input  wire logic                   nrst,
	input  wire logic                   sclClk,
	input  wire logic                   sdaIn,
	output logic                        sdaOut,
	output logic                        sdaOe,
	input  wire logic                   chipEnableStrapLow,
	input  wire logic                   chipEnableStrapHigh,
	output logic                        wrValid,
	input  wire logic                   wrReady,
	output its_wreq_s                   wrReq,
	output logic [`ITS_ADDR_W-1:0]      rdAddr,
	input  wire logic [`ITS_DATA_W-1:0] rdData,
	output logic                        busy
);

////////////////////////////////////////////////////////////////////////////////
// link side: bits sampled on the master's clock rise

	logic linkBit_r;
	logic linkTog_r;

	always_ff @(posedge sclClk or negedge nrst) begin
		if (!nrst) begin
			linkBit_r <= 1'b0;
			linkTog_r <= 1'b0;
		end else begin
			linkBit_r <= sdaIn;
			linkTog_r <= ~linkTog_r;
		end
	end

////////////////////////////////////////////////////////////////////////////////
// crossings into the system clock

	logic       togMeta_r;
	logic       togSync_r;
	logic       togPrev_r;
	logic [3:0] pinMeta_r;
	logic [3:0] pinSync_r;
	logic [1:0] pinPrev_r;
	logic       bitEv;
	logic       sclFall;
	logic       startEv;
	logic       stopEv;
	logic [1:0] strapLvl;

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			togMeta_r <= 1'b0;
			togSync_r <= 1'b0;
			togPrev_r <= 1'b0;
		end else begin
			togMeta_r <= linkTog_r;
			togSync_r <= togMeta_r;
			togPrev_r <= togSync_r;
		end
	end

	// the bus clock level is also sampled here, only to find start, stop and falling edges
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			pinMeta_r <= {`ITS_STRAP_RST, 2'h3};
			pinSync_r <= {`ITS_STRAP_RST, 2'h3};
			pinPrev_r <= 2'h3;
		end else begin
			pinMeta_r <= {chipEnableStrapHigh, chipEnableStrapLow, sdaIn, sclClk};
			pinSync_r <= pinMeta_r;
			pinPrev_r <= pinSync_r[1:0];
		end
	end

	// the bit register is stable for a whole bus clock period once the toggle lands
	assign bitEv    = togSync_r ^ togPrev_r;
	assign sclFall  = pinPrev_r[0] & ~pinSync_r[0];
	assign startEv  = pinPrev_r[0] & pinSync_r[0] & pinPrev_r[1] & ~pinSync_r[1];
	assign stopEv   = pinPrev_r[0] & pinSync_r[0] & ~pinPrev_r[1] & pinSync_r[1];
	// floating straps rely on the pad pull-downs, so an open pin samples as zero
	assign strapLvl = pinSync_r[3:2];

////////////////////////////////////////////////////////////////////////////////
// select decode

	function automatic logic selMatch(input logic [7:0] sel, input logic [1:0] strap);
		selMatch = (sel[`ITS_TYPE_MSB:`ITS_TYPE_LSB] == TYPE_ID)
			&& (sel[`ITS_STRAP_MSB:`ITS_STRAP_LSB] == strap)
			&& (sel[`ITS_SEL_POS] == INT_SEL);
	endfunction

	its_state_e             state_r;
	logic [3:0]             cnt_r;
	logic                   ackOn_r;
	logic                   ackGive_r;
	logic                   rw_r;
	logic [7:0]             shift_r;
	logic [`ITS_ADDR_HI_W-1:0] addrHi_r;
	logic [`ITS_ADDR_W-1:0] addr_r;
	logic [7:0]             rxByte;
	logic                   rxState;
	logic                   byteDone;
	logic                   selOk;
	logic                   fifoReady;
	logic                   wrPush;
	logic                   loadNow;

	assign rxState  = (state_r == ITS_DEVSEL) || (state_r == ITS_ADDR_HI)
		|| (state_r == ITS_ADDR_LO) || (state_r == ITS_WDATA);
	assign rxByte   = {shift_r[6:0], linkBit_r};
	assign byteDone = bitEv && rxState && (cnt_r == `ITS_LAST_BIT);
	assign selOk    = selMatch(rxByte, strapLvl);
	assign wrPush   = byteDone && (state_r == ITS_WDATA) && fifoReady;
	assign loadNow  = sclFall && (((state_r == ITS_ACK_SEL) && ackOn_r && rw_r)
		|| ((state_r == ITS_RDATA) && (cnt_r == 4'h0)));

////////////////////////////////////////////////////////////////////////////////
// framing state

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			state_r   <= ITS_IDLE;
			cnt_r     <= 4'h0;
			ackOn_r   <= 1'b0;
			ackGive_r <= 1'b0;
		end else if (stopEv) begin
			state_r <= ITS_IDLE;
			cnt_r   <= 4'h0;
			ackOn_r <= 1'b0;
		end else if (startEv) begin
			state_r <= ITS_DEVSEL;
			cnt_r   <= 4'h0;
			ackOn_r <= 1'b0;
		end else begin
			unique case (state_r)
				ITS_IDLE: begin
					cnt_r <= 4'h0;
				end
				ITS_DEVSEL, ITS_ADDR_HI, ITS_ADDR_LO, ITS_WDATA: begin
					if (byteDone) begin
						cnt_r     <= 4'h0;
						ackGive_r <= 1'b1;
						unique case (state_r)
							ITS_DEVSEL: state_r <= selOk ? ITS_ACK_SEL : ITS_IDLE;
							ITS_ADDR_HI: state_r <= ITS_ACK_HI;
							ITS_ADDR_LO: state_r <= ITS_ACK_LO;
							default: begin
								state_r   <= ITS_ACK_W;
								// a full buffer refuses the byte rather than dropping it
								ackGive_r <= fifoReady;
							end
						endcase
					end else if (bitEv) begin
						cnt_r <= cnt_r + 1'b1;
					end
				end
				ITS_ACK_SEL, ITS_ACK_HI, ITS_ACK_LO, ITS_ACK_W: begin
					if (sclFall && !ackOn_r) begin
						ackOn_r <= 1'b1;
					end else if (sclFall) begin
						ackOn_r <= 1'b0;
						unique case (state_r)
							ITS_ACK_SEL: state_r <= rw_r ? ITS_RDATA : ITS_ADDR_HI;
							ITS_ACK_HI: state_r <= ITS_ADDR_LO;
							default: state_r <= ITS_WDATA;
						endcase
					end
				end
				ITS_RDATA: begin
					if (bitEv && (cnt_r == `ITS_LAST_BIT)) begin
						cnt_r   <= 4'h0;
						state_r <= ITS_RACK;
					end else if (bitEv) begin
						cnt_r <= cnt_r + 1'b1;
					end
				end
				ITS_RACK: begin
					if (bitEv) begin
						// a no-ack ends the read, only a stop or start is awaited
						state_r <= linkBit_r ? ITS_IDLE : ITS_RDATA;
					end
				end
				default: begin
					state_r <= ITS_IDLE;
				end
			endcase
		end
	end

////////////////////////////////////////////////////////////////////////////////
// shifter, direction and address

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			shift_r <= 8'h00;
		end else if (bitEv && rxState) begin
			shift_r <= rxByte;
		end else if (loadNow) begin
			shift_r <= rdData;
		end else if (sclFall && (state_r == ITS_RDATA)) begin
			shift_r <= {shift_r[6:0], 1'b0};
		end
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			rw_r <= 1'b0;
		end else if (byteDone && (state_r == ITS_DEVSEL)) begin
			rw_r <= rxByte[`ITS_RW_POS];
		end
	end

	// the address survives a repeated start, which gives the random read
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			addrHi_r <= '0;
			addr_r   <= '0;
		end else if (byteDone && (state_r == ITS_ADDR_HI)) begin
			addrHi_r <= rxByte[`ITS_ADDR_HI_W-1:0];
		end else if (byteDone && (state_r == ITS_ADDR_LO)) begin
			addr_r <= {addrHi_r, rxByte};
		end else if (wrPush || (bitEv && (state_r == ITS_RDATA) && (cnt_r == `ITS_LAST_BIT))) begin
			addr_r <= addr_r + 1'b1;
		end
	end

////////////////////////////////////////////////////////////////////////////////
// open-drain data line, changed only after the clock falls or on a start or stop

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			sdaOe <= 1'b0;
		end else if (startEv || stopEv) begin
			sdaOe <= 1'b0;
		end else if (loadNow) begin
			sdaOe <= ~rdData[7];
		end else if (sclFall) begin
			unique case (state_r)
				ITS_ACK_SEL, ITS_ACK_HI, ITS_ACK_LO, ITS_ACK_W: begin
					sdaOe <= ackGive_r && !ackOn_r;
				end
				ITS_RDATA: begin
					sdaOe <= ~shift_r[6];
				end
				default: begin
					sdaOe <= 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			sdaOut <= 1'b0;
			busy   <= 1'b0;
			rdAddr <= '0;
		end else begin
			sdaOut <= 1'b0;
			busy   <= (state_r != ITS_IDLE);
			rdAddr <= addr_r;
		end
	end

////////////////////////////////////////////////////////////////////////////////
// write buffer toward the memory

	its_fifo #(
		.WIDTH ($bits(its_wreq_s)),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.clock    (clock),
		.nrst     (nrst),
		.inValid  (wrPush),
		.inReady  (fifoReady),
		.inData   ({addr_r, rxByte}),
		.outValid (wrValid),
		.outReady (wrReady),
		.outData  (wrReq)
	);

////////////////////////////////////////////////////////////////////////////////
// checks

	default clocking cb @(posedge clock); endclocking
	default disable iff (!nrst);

	sequence selByteIn;
		byteDone && (state_r == ITS_DEVSEL) && selOk;
	endsequence

	sequence ackSlot;
		(state_r inside {ITS_ACK_SEL, ITS_ACK_HI, ITS_ACK_LO}) && sclFall && !ackOn_r
			&& !startEv && !stopEv;
	endsequence

	oeOnFall_a: assert property ($changed(sdaOe) |-> $past(sclFall || startEv || stopEv))
		else $error("data line changed while bus clock not falling");

	selAck_a: assert property (selByteIn ##1 (!startEv && !stopEv) |-> state_r == ITS_ACK_SEL)
		else $error("matching select not taken to acknowledge");

	ackDrive_a: assert property (ackSlot |=> sdaOe)
		else $error("acknowledge not driven low");

	selReject_a: assert property (byteDone && (state_r == ITS_DEVSEL) && !selOk
		&& !startEv && !stopEv |=> (state_r == ITS_IDLE) && !sdaOe)
		else $error("mismatching select not ignored");

	typeMatch_a: assert property ((state_r == ITS_ACK_SEL)
		&& ($past(state_r) == ITS_DEVSEL) |-> ($past(rxByte[7:4]) == TYPE_ID)
		&& ($past(rxByte[`ITS_SEL_POS]) == INT_SEL))
		else $error("select accepted with wrong type code");

	strapMatch_a: assert property ((state_r == ITS_ACK_SEL)
		&& ($past(state_r) == ITS_DEVSEL) |-> $past(rxByte[2:1]) == $past(strapLvl))
		else $error("select accepted with wrong strap bits");

	addrStep_a: assert property (wrPush && !startEv |=> addr_r == $past(addr_r) + 1'b1)
		else $error("address not stepped after write");

	startOpen_a: assert property (startEv && !stopEv |=> (state_r == ITS_DEVSEL)
		&& (cnt_r == 4'h0) && !sdaOe)
		else $error("start did not open select phase");

	readBit_a: assert property ((state_r == ITS_RDATA) && sclFall
		&& (cnt_r != 4'h0) && !startEv && !stopEv |=> sdaOe == ~$past(shift_r[6]))
		else $error("read bit driven with wrong level");

endmodule

//--- its_bus_master.sv
// two-wire bus master model that drives the target's serial link
`timescale 1ns/100ps
module its_bus_master (
	output logic      sclClk,
	output logic      drvLow,
	input  wire logic sdaLine
);
	logic tick;

	initial begin
		tick = 1'b0;
		sclClk = 1'b1;
		drvLow = 1'b0;
	end

	// link time base of 30 ns, unrelated in phase to the system clock
	always #15 tick = ~tick;

	////////////////////////////////////////////////////////////////////////////////
	// a quarter bit: scl low and high each last two of them, 300 ns
	task automatic q();
		repeat (5) @(posedge tick);
	endtask

	// clock made here and in start and stop only, and only inside frames
	task automatic bit_cycle(input logic low, output logic seen);
		q();
		drvLow = low;
		q();
		sclClk = 1'b1;
		q();
		seen = sdaLine;
		q();
		sclClk = 1'b0;
	endtask

	// start or repeated start, sda falls while scl is high
	task automatic start();
		if (!sclClk) begin
			q();
			drvLow = 1'b0;
			q();
			sclClk = 1'b1;
		end
		q();
		drvLow = 1'b1;
		q();
		sclClk = 1'b0;
	endtask

	// stop, sda rises while scl is high; line left released
	task automatic stop();
		q();
		drvLow = 1'b1;
		q();
		sclClk = 1'b1;
		q();
		drvLow = 1'b0;
		q();
	endtask

	// byte out msb first, then the ninth slot released for the target
	task automatic wbyte(input logic [7:0] b, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			bit_cycle(~b[i], s);
		end
		bit_cycle(1'b0, s);
		ack = ~s;
	endtask

	// byte in, then our own acknowledge or no-ack in the ninth slot
	task automatic rbyte(input logic ackIt, output logic [7:0] d);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			bit_cycle(1'b0, d[i]);
		end
		bit_cycle(ackIt, s);
	endtask
endmodule

//--- tb.sv
// self-checking bench of the two-wire target
`timescale 1ns/100ps
`include "its_defs.svh"
`define ITS_CHECK(what, exp, got) \
	begin \
		comparisons++; \
		if ((got) !== (exp)) begin \
			miscompares++; \
			$display("CHECK FAILED %s expected %0h seen %0h", what, exp, got); \
		end \
	end
module tb;
	import its_pkg::*;
	localparam logic [3:0] TYPE_ID = `ITS_TYPE_ID;
	logic                  clock;
	logic                  nrst;
	logic                  sclClk;
	logic                  sdaOut;
	logic                  sdaOe;
	logic                  mDrvLow;
	logic                  sdaIn;
	logic                  strapLo;
	logic                  strapHi;
	logic                  wrValid;
	logic                  wrReady;
	logic                  busy;
	its_wreq_s             wrReq;
	logic [12:0]           rdAddr;
	logic [7:0]            rdData;
	logic [7:0]            mem [0:8191];
	its_wreq_s             gotQ [$];
	int                    miscompares;
	int                    comparisons;
	logic                  ack;
	logic [7:0]            rd;

	// pull-up: line low when any party pulls
	assign sdaIn = ~(sdaOe | mDrvLow);

	its_target u_its_target (.clock(clock), .nrst(nrst), .sclClk(sclClk), .sdaIn(sdaIn),
		.sdaOut(sdaOut), .sdaOe(sdaOe), .chipEnableStrapLow(strapLo),
		.chipEnableStrapHigh(strapHi), .wrValid(wrValid), .wrReady(wrReady), .wrReq(wrReq),
		.rdAddr(rdAddr), .rdData(rdData), .busy(busy));
	its_bus_master u_its_bus_master (.sclClk(sclClk), .drvLow(mDrvLow), .sdaLine(sdaIn));

	initial clock = 1'b0;
	always #4 clock = ~clock;

	////////////////////////////////////////////////////////////////////////////////
	// memory side: registered read, writes logged for comparison
	always @(posedge clock) begin
		rdData <= mem[rdAddr];
		if (nrst && wrValid && wrReady) begin
			gotQ.push_back(wrReq);
			mem[wrReq.addr] <= wrReq.data;
		end
	end

	always @(posedge clock) begin
		if (nrst) `ITS_CHECK("sdaOut", 1'b0, sdaOut)
	end

	task automatic tally_and_finish();
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	function automatic logic [7:0] selByte(input logic b3, input logic [1:0] ce, input logic rw);
		return {TYPE_ID, b3, ce, rw};
	endfunction

	// straps pass a synchroniser, so give them a few cycles
	task automatic setStraps(input logic hi, input logic lo);
		@(posedge clock);
		strapHi <= hi;
		strapLo <= lo;
		repeat (6) @(posedge clock);
	endtask

	task automatic putAddr(input logic [15:0] a);
		u_its_bus_master.start();
		u_its_bus_master.wbyte(selByte(1'b0, {strapHi, strapLo}, 1'b0), ack);
		`ITS_CHECK("select ack", 1'b1, ack)
		u_its_bus_master.wbyte(a[15:8], ack);
		`ITS_CHECK("addr hi ack", 1'b1, ack)
		u_its_bus_master.wbyte(a[7:0], ack);
		`ITS_CHECK("addr lo ack", 1'b1, ack)
		`ITS_CHECK("busy", 1'b1, busy)
	endtask

	////////////////////////////////////////////////////////////////////////////////
	task automatic test_write_wrap();
		setStraps(1'b1, 1'b0);
		gotQ.delete();
		putAddr(16'hFFFF);
		u_its_bus_master.wbyte(8'h3C, ack);
		`ITS_CHECK("data ack", 1'b1, ack)
		u_its_bus_master.wbyte(8'hC3, ack);
		`ITS_CHECK("data ack", 1'b1, ack)
		u_its_bus_master.stop();
		repeat (20) @(posedge clock);
		`ITS_CHECK("busy", 1'b0, busy)
		`ITS_CHECK("writes", 2, gotQ.size())
		`ITS_CHECK("last location", {13'h1FFF, 8'h3C}, gotQ[0])
		`ITS_CHECK("wrapped location", {13'h0000, 8'hC3}, gotQ[1])
	endtask

	task automatic test_read();
		setStraps(1'b0, 1'b1);
		putAddr(16'h0123);
		u_its_bus_master.start();
		u_its_bus_master.wbyte(selByte(1'b0, 2'b01, 1'b1), ack);
		`ITS_CHECK("read select ack", 1'b1, ack)
		u_its_bus_master.rbyte(1'b1, rd);
		`ITS_CHECK("read byte", 8'h23 ^ 8'hA5, rd)
		u_its_bus_master.rbyte(1'b0, rd);
		`ITS_CHECK("next byte", 8'h24 ^ 8'hA5, rd)
		u_its_bus_master.stop();
	endtask

	// wrong type, wrong straps, internal select set, wrong straps on a read
	task automatic test_mismatch();
		logic [7:0] bad [4];
		bad[0] = {TYPE_ID ^ 4'h1, 1'b0, 2'b11, 1'b0};
		bad[1] = {TYPE_ID, 1'b0, 2'b01, 1'b0};
		bad[2] = {TYPE_ID, 1'b1, 2'b11, 1'b0};
		bad[3] = {TYPE_ID, 1'b0, 2'b10, 1'b1};
		setStraps(1'b1, 1'b1);
		gotQ.delete();
		for (int i = 0; i < 4; i++) begin
			u_its_bus_master.start();
			u_its_bus_master.wbyte(bad[i], ack);
			`ITS_CHECK("foreign select", 1'b0, ack)
			u_its_bus_master.wbyte(8'h00, ack);
			`ITS_CHECK("ignored byte", 1'b0, ack)
			u_its_bus_master.start();
			u_its_bus_master.wbyte(selByte(1'b0, 2'b11, 1'b0), ack);
			`ITS_CHECK("select after start", 1'b1, ack)
			u_its_bus_master.stop();
		end
		`ITS_CHECK("no writes", 0, gotQ.size())
	endtask

	// straps at zero; memory stalls, so the ninth byte finds the buffer full
	task automatic test_fifo_full();
		setStraps(1'b0, 1'b0);
		@(posedge clock);
		wrReady <= 1'b0;
		gotQ.delete();
		putAddr(16'h0010);
		for (int i = 0; i < 9; i++) begin
			u_its_bus_master.wbyte(8'h40 + i[7:0], ack);
			`ITS_CHECK("stalled ack", (i < `ITS_FIFO_DEPTH), ack)
		end
		u_its_bus_master.stop();
		@(posedge clock);
		wrReady <= 1'b1;
		repeat (30) @(posedge clock);
		`ITS_CHECK("drained", `ITS_FIFO_DEPTH, gotQ.size())
		for (int i = 0; i < 8; i++) begin
			`ITS_CHECK("drained word", {13'h0010 + i[12:0], 8'h40 + i[7:0]}, gotQ[i])
		end
	endtask

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		nrst = 1'b0;
		wrReady = 1'b1;
		strapLo = 1'b0;
		strapHi = 1'b0;
		miscompares = 0;
		comparisons = 0;
		for (int i = 0; i < 8192; i++) begin
			mem[i] = i[7:0] ^ 8'hA5;
		end
		repeat (6) @(posedge clock);
		nrst <= 1'b1;
		repeat (6) @(posedge clock);
		test_write_wrap();
		test_read();
		test_mismatch();
		test_fifo_full();
		tally_and_finish();
	end

	// the tests need about 25000 cycles
	initial begin
		repeat (75000) @(posedge clock);
		miscompares++;
		$display("CHECK FAILED watchdog expected done seen hang");
		tally_and_finish();
	end
endmodule
